// ---- shared/twb_pkg.sv ----
/*
  Constants, states and field layouts of the two-wire bus slave engine.
  Assumes a user clock domain and a separate, faster link sampling clock.
*/
package twb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Packet layout

  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] RESERVED_TOP = 4'hf;
  localparam logic RW_READ = 1'b1;
  localparam logic LINE_LOW = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Configuration word carried into the link domain

  localparam int CFG_W = 10;
  localparam int CFG_GC = 7;
  localparam int CFG_ACK = 8;
  localparam int CFG_PR = 9;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h200;

  ////////////////////////////////////////////////////////////////////////
  // Status and event groups carried into the user domain

  localparam int ST_W = 4;
  localparam int ST_GC = 0;
  localparam int ST_RW = 1;
  localparam int ST_ADDR = 2;
  localparam int ST_BUSY = 3;
  localparam int EV_W = 5;
  localparam int EV_RX = 0;
  localparam int EV_STOP = 1;
  localparam int EV_EMPTY = 2;
  localparam int EV_NACK = 3;
  localparam int EV_REQ = 4;

  typedef enum logic [2:0] {
    TWB_IDLE,
    TWB_ADDR,
    TWB_ADDR_ACK,
    TWB_RX,
    TWB_RX_ACK,
    TWB_TX,
    TWB_TX_ACK,
    TWB_WAIT_TX
  } twb_state_type;

  localparam twb_state_type STATE_RESET = TWB_IDLE;

endpackage

// ---- src/twb_slave.sv ----
/*
  Two-wire bus slave engine: link side on link_clk, user side on clk.
  Assumes external pull-ups, a link_clk far faster than SCL, and a user
  that gives no second tx_load before the link has taken the held byte.
*/
`timescale 1ns/10ps
module twb_slave
  import twb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic serial_bus_power_reduction,
  input wire logic [ADDR_W-1:0] own_addr,
  input wire logic gen_call_en,
  input wire logic ack_en,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_load,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic bus_busy,
  output logic addressed,
  output logic read_mode,
  output logic gen_call,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic tx_req,
  output logic stop_seen,
  output logic empty_msg,
  output logic nack_seen
);

  ////////////////////////////////////////////////////////////////////////
  // State of both domains

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [CFG_W-1:0] cfg1;
    logic [CFG_W-1:0] cfg2;
    logic tx1;
    logic tx2;
    logic tx3;
    twb_state_type state;
    logic [3:0] cnt;
    logic [BYTE_W-1:0] sh;
    logic [BYTE_W-1:0] txsh;
    logic rw;
    logic tx_have;
    logic busy;
    logic addressed;
    logic gen_call;
    logic data_seen;
    logic sda_oe;
    logic scl_oe;
    logic line_lo;
    logic [BYTE_W-1:0] rx_data;
    logic [EV_W-1:0] ev_tgl;
  } twb_link_type;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [BYTE_W-1:0] tx_hold;
    logic tx_tgl;
    logic [ST_W-1:0] st1;
    logic [ST_W-1:0] st2;
    logic [EV_W-1:0] ev1;
    logic [EV_W-1:0] ev2;
    logic [EV_W-1:0] ev3;
    logic [BYTE_W-1:0] rx_data;
    logic [EV_W-1:0] pulse;
  } twb_user_type;

  localparam twb_link_type LINK_RESET = '{
    scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
    cfg1: CFG_RESET, cfg2: CFG_RESET, state: STATE_RESET,
    cnt: CNT_ZERO, line_lo: LINE_LOW, default: '0};

  localparam twb_user_type USER_RESET = '{
    cfg: CFG_RESET, default: '0};

  twb_link_type l_r;
  twb_link_type l_nxt;
  twb_user_type u_r;
  twb_user_type u_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Reserved block is refused even if own_addr is set into it
  function automatic logic addr_match(input logic [BYTE_W-1:0] pkt,
                                      input logic [CFG_W-1:0] cfg);
    logic [ADDR_W-1:0] a;
    a = pkt[BYTE_W-1:1];
    addr_match = 1'b0;
    if (a[ADDR_W-1 -: 4] != RESERVED_TOP)
    begin
      if (a == cfg[ADDR_W-1:0])
        addr_match = 1'b1;
      if (cfg[CFG_GC] && a == GEN_CALL_ADDR && pkt[0] != RW_READ)
        addr_match = 1'b1;
    end
  endfunction

  function automatic logic tgl_edge(input logic a, input logic b);
    tgl_edge = a ^ b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sampled line events, taken from the second synchroniser stage

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic pr_l;
  logic match_l;
  logic ack_ok;

  assign scl_rise = l_r.scl_s[1] && !l_r.scl_d;
  assign scl_fall = !l_r.scl_s[1] && l_r.scl_d;
  assign start_det = l_r.scl_s[1] && l_r.scl_d && l_r.sda_d
                     && !l_r.sda_s[1];
  assign stop_det = l_r.scl_s[1] && l_r.scl_d && !l_r.sda_d
                    && l_r.sda_s[1];
  assign pr_l = l_r.cfg2[CFG_PR];
  assign match_l = addr_match(l_r.sh, l_r.cfg2);
  assign ack_ok = match_l && l_r.cfg2[CFG_ACK];

  ////////////////////////////////////////////////////////////////////////
  // Link domain

  always_comb
  begin
    logic want_tx;
    want_tx = 1'b0;
    l_nxt = l_r;
    l_nxt.scl_s = {l_r.scl_s[0], scl_i};
    l_nxt.sda_s = {l_r.sda_s[0], sda_i};
    l_nxt.scl_d = l_r.scl_s[1];
    l_nxt.sda_d = l_r.sda_s[1];
    l_nxt.cfg1 = u_r.cfg;
    l_nxt.cfg2 = l_r.cfg1;
    l_nxt.tx1 = u_r.tx_tgl;
    l_nxt.tx2 = l_r.tx1;
    l_nxt.tx3 = l_r.tx2;
    unique case (l_r.state)
      TWB_IDLE:
      begin
      end
      TWB_ADDR:
      begin
        if (scl_rise)
        begin
          // One bit per clock pulse, first bit lands on top
          l_nxt.sh = {l_r.sh[BYTE_W-2:0], l_r.sda_s[1]};
          l_nxt.cnt = l_r.cnt + 4'h1;
        end
        else if (scl_fall && l_r.cnt == BITS_PER_BYTE)
        begin
          l_nxt.rw = l_r.sh[0];
          if (ack_ok)
          begin
            l_nxt.sda_oe = 1'b1;
            l_nxt.state = TWB_ADDR_ACK;
            l_nxt.addressed = 1'b1;
            l_nxt.gen_call = l_r.sh[BYTE_W-1:1] == GEN_CALL_ADDR;
          end
          else
            l_nxt.state = TWB_IDLE;
        end
      end
      TWB_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          l_nxt.sda_oe = 1'b0;
          l_nxt.cnt = CNT_ZERO;
          if (l_r.rw == RW_READ)
            want_tx = 1'b1;
          else
            l_nxt.state = TWB_RX;
        end
      end
      TWB_RX:
      begin
        if (scl_rise)
        begin
          l_nxt.sh = {l_r.sh[BYTE_W-2:0], l_r.sda_s[1]};
          l_nxt.cnt = l_r.cnt + 4'h1;
        end
        else if (scl_fall && l_r.cnt == BITS_PER_BYTE)
        begin
          l_nxt.rx_data = l_r.sh;
          l_nxt.ev_tgl[EV_RX] = !l_r.ev_tgl[EV_RX];
          l_nxt.data_seen = 1'b1;
          // Refusing further bytes answers with a released line
          l_nxt.sda_oe = l_r.cfg2[CFG_ACK];
          l_nxt.state = TWB_RX_ACK;
        end
      end
      TWB_RX_ACK:
      begin
        if (scl_fall)
        begin
          l_nxt.sda_oe = 1'b0;
          l_nxt.cnt = CNT_ZERO;
          l_nxt.state = TWB_RX;
        end
      end
      TWB_TX:
      begin
        if (scl_rise)
          l_nxt.cnt = l_r.cnt + 4'h1;
        else if (scl_fall)
        begin
          if (l_r.cnt == BITS_PER_BYTE)
          begin
            l_nxt.sda_oe = 1'b0;
            l_nxt.state = TWB_TX_ACK;
          end
          else
          begin
            l_nxt.txsh = {l_r.txsh[BYTE_W-2:0], 1'b0};
            l_nxt.sda_oe = !l_r.txsh[BYTE_W-2];
          end
        end
      end
      TWB_TX_ACK:
      begin
        if (scl_rise)
          l_nxt.sh[0] = l_r.sda_s[1];
        else if (scl_fall)
        begin
          l_nxt.data_seen = 1'b1;
          l_nxt.cnt = CNT_ZERO;
          if (!l_r.sh[0])
            want_tx = 1'b1;
          else
          begin
            // Master ended the read; wait for stop or restart
            l_nxt.ev_tgl[EV_NACK] = !l_r.ev_tgl[EV_NACK];
            l_nxt.state = TWB_IDLE;
          end
        end
      end
      TWB_WAIT_TX:
      begin
        want_tx = l_r.tx_have;
      end
    endcase
    if (want_tx)
    begin
      if (l_r.tx_have)
      begin
        l_nxt.txsh = u_r.tx_hold;
        l_nxt.sda_oe = !u_r.tx_hold[BYTE_W-1];
        l_nxt.tx_have = 1'b0;
        l_nxt.scl_oe = 1'b0;
        l_nxt.state = TWB_TX;
      end
      else
      begin
        // Holding SCL low until the user supplies a byte
        l_nxt.scl_oe = 1'b1;
        l_nxt.state = TWB_WAIT_TX;
        l_nxt.ev_tgl[EV_REQ] = !l_r.ev_tgl[EV_REQ];
      end
    end
    // A fresh byte beats the consume of the old one
    if (tgl_edge(l_r.tx2, l_r.tx3))
      l_nxt.tx_have = 1'b1;
    if (start_det)
    begin
      l_nxt.state = TWB_ADDR;
      l_nxt.busy = 1'b1;
      l_nxt.cnt = CNT_ZERO;
      l_nxt.addressed = 1'b0;
      l_nxt.gen_call = 1'b0;
      l_nxt.data_seen = 1'b0;
      l_nxt.sda_oe = 1'b0;
      l_nxt.scl_oe = 1'b0;
    end
    if (stop_det)
    begin
      l_nxt.state = TWB_IDLE;
      l_nxt.busy = 1'b0;
      l_nxt.addressed = 1'b0;
      l_nxt.gen_call = 1'b0;
      l_nxt.sda_oe = 1'b0;
      l_nxt.scl_oe = 1'b0;
      l_nxt.ev_tgl[EV_STOP] = !l_r.ev_tgl[EV_STOP];
      if (l_r.busy && !l_r.data_seen)
        l_nxt.ev_tgl[EV_EMPTY] = !l_r.ev_tgl[EV_EMPTY];
    end
    if (pr_l)
    begin
      // Powered down: no drive, no tracking of the bus
      l_nxt.state = TWB_IDLE;
      l_nxt.ev_tgl = l_r.ev_tgl;
      l_nxt.busy = 1'b0;
      l_nxt.addressed = 1'b0;
      l_nxt.gen_call = 1'b0;
      l_nxt.sda_oe = 1'b0;
      l_nxt.scl_oe = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      l_r <= LINK_RESET;
    else
      l_r <= l_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // User domain

  always_comb
  begin
    u_nxt = u_r;
    u_nxt.cfg = {serial_bus_power_reduction, ack_en, gen_call_en, own_addr};
    if (tx_load)
    begin
      u_nxt.tx_hold = tx_data;
      u_nxt.tx_tgl = !u_r.tx_tgl;
    end
    u_nxt.st1 = {l_r.busy, l_r.addressed, l_r.rw, l_r.gen_call};
    u_nxt.st2 = u_r.st1;
    u_nxt.ev1 = l_r.ev_tgl;
    u_nxt.ev2 = u_r.ev1;
    u_nxt.ev3 = u_r.ev2;
    u_nxt.pulse = u_r.ev2 ^ u_r.ev3;
    // Link data is long settled once its toggle has crossed
    if (tgl_edge(u_r.ev2[EV_RX], u_r.ev3[EV_RX]))
      u_nxt.rx_data = l_r.rx_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      u_r <= USER_RESET;
    else
      u_r <= u_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign scl_o = l_r.line_lo;
  assign sda_o = l_r.line_lo;
  assign scl_oe = l_r.scl_oe;
  assign sda_oe = l_r.sda_oe;
  assign bus_busy = u_r.st2[ST_BUSY];
  assign addressed = u_r.st2[ST_ADDR];
  assign read_mode = u_r.st2[ST_RW];
  assign gen_call = u_r.st2[ST_GC];
  assign rx_data = u_r.rx_data;
  assign rx_valid = u_r.pulse[EV_RX];
  assign tx_req = u_r.pulse[EV_REQ];
  assign stop_seen = u_r.pulse[EV_STOP];
  assign empty_msg = u_r.pulse[EV_EMPTY];
  assign nack_seen = u_r.pulse[EV_NACK];

  ////////////////////////////////////////////////////////////////////////
  // Checks on the link side

  a_sda_stable: assert property (
    @(posedge link_clk) disable iff (link_rst)
    $changed(l_r.sda_oe) |-> !$past(l_r.scl_s[1]) || $past(pr_l))
    else $error("data drive changed while clock high");

  a_start_busy: assert property (
    @(posedge link_clk) disable iff (link_rst)
    start_det && !pr_l |=> l_r.busy && l_r.state == TWB_ADDR
      && l_r.cnt == CNT_ZERO)
    else $error("start did not open an address packet");

  a_stop_idle: assert property (
    @(posedge link_clk) disable iff (link_rst)
    stop_det |=> !l_r.busy && !l_r.sda_oe && l_r.state == TWB_IDLE)
    else $error("stop did not free the bus");

  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.state == TWB_ADDR && scl_fall && l_r.cnt == BITS_PER_BYTE
      && ack_ok && !start_det && !stop_det && !pr_l
    |=> l_r.sda_oe && l_r.addressed && l_r.rw == $past(l_r.sh[0]))
    else $error("own address not acknowledged");

  a_addr_nack: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.state == TWB_ADDR && scl_fall && l_r.cnt == BITS_PER_BYTE
      && !ack_ok |=> !l_r.sda_oe && l_r.state != TWB_ADDR_ACK)
    else $error("refused address was acknowledged");

  a_addr_rsvd: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.state == TWB_ADDR_ACK |-> l_r.sh[BYTE_W-1 -: 4] != RESERVED_TOP)
    else $error("reserved address matched");

  a_gc_write: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.gen_call |-> l_r.rw != RW_READ)
    else $error("general call taken with read bit");

  a_stretch_hold: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.state == TWB_WAIT_TX && !l_r.tx_have && !start_det && !stop_det
      && !pr_l |=> l_r.scl_oe && l_r.state == TWB_WAIT_TX)
    else $error("clock released before a byte was ready");

  a_tx_msb: assert property (
    @(posedge link_clk) disable iff (link_rst)
    l_r.state == TWB_TX && $past(l_r.state) != TWB_TX
    |-> l_r.sda_oe == !l_r.txsh[BYTE_W-1] && !l_r.scl_oe)
    else $error("first bit of a byte is not the top bit");

  a_pr_quiet: assert property (
    @(posedge link_clk) disable iff (link_rst)
    pr_l |=> !l_r.sda_oe && !l_r.scl_oe && !l_r.busy)
    else $error("bus driven while powered down");

endmodule // twb_slave

// ---- sim/twb_master.sv ----
/*
  Behavioural bus master that drives the far side of the two-wire slave.
  Assumes pull-ups on both lines, with the wired-AND formed by the bench.
*/
`timescale 1ns/10ps
module twb_master
#(
  parameter int T = 200
)
(
  input wire logic scl,
  input wire logic sda,
  output logic scl_drive,
  output logic sda_drive
);

  // High means pull the line low; a one is never driven
  initial
  begin
    scl_drive = 1'b0;
    sda_drive = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data set mid-low, so it never moves while the clock is high
  task automatic send_bit(input logic b, output logic r);
    #(T/2);
    sda_drive = !b;
    #(T/2);
    scl_drive = 1'b0;
    wait (scl === 1'b1);
    #T;
    r = sda;
    scl_drive = 1'b1;
  endtask

  // Works from idle and as a repeated start
  task automatic start();
    #(T/2);
    sda_drive = 1'b0;
    #(T/2);
    scl_drive = 1'b0;
    wait (scl === 1'b1);
    #T;
    sda_drive = 1'b1;
    #T;
    scl_drive = 1'b1;
  endtask

  task automatic stop();
    #(T/2);
    sda_drive = 1'b1;
    #(T/2);
    scl_drive = 1'b0;
    wait (scl === 1'b1);
    #T;
    sda_drive = 1'b0;
    #T;
  endtask

  // Eight bits then the acknowledge slot; reads send all ones
  task automatic byte_xfer(input logic [7:0] d, input logic ack_bit,
                           output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      send_bit(d[i], q[i]);
    end
    send_bit(ack_bit, a);
  endtask

endmodule // twb_master

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the two-wire slave engine.
  Assumes the master model twb_master and pull-ups on both lines.
*/
`timescale 1ns/10ps
module testbench;

  logic clk, rst, link_clk, link_rst, pwr_down, gce, acken, tx_load;
  logic [6:0] own;
  logic [7:0] tx_data, rx_data, q, q2;
  logic scl, sda, m_scl, m_sda, scl_o, scl_oe, sda_o, sda_oe, a, hold;
  logic bus_busy, addressed, read_mode, gen_call;
  logic rx_valid, tx_req, stop_seen, empty_msg, nack_seen;
  int fails = 0, comparisons = 0, cycles = 0;
  int n_rx = 0, n_empty = 0, n_req = 0, n_nack = 0, n_stop = 0;
  int e_rx = 0, e_empty = 0;
  // own[30:24] wire byte[23:16] gce[14] acken[13] ack[12] data[7:0]
  logic [31:0] rows [8] = '{32'h2a54_3096, 32'h2a54_0011, 32'h2a00_7081,
    32'h2a00_2000, 32'h7bf6_20a5, 32'h2a01_6000, 32'h2a56_2000,
    32'h77ee_30fe};

  // Pull-ups: a released line reads high
  assign scl = !(m_scl | scl_oe);
  assign sda = !(m_sda | sda_oe);

  twb_slave i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .link_rst(link_rst), .serial_bus_power_reduction(pwr_down),
    .own_addr(own), .gen_call_en(gce), .ack_en(acken),
    .tx_data(tx_data), .tx_load(tx_load), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .bus_busy(bus_busy), .addressed(addressed), .read_mode(read_mode),
    .gen_call(gen_call), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_req(tx_req), .stop_seen(stop_seen), .empty_msg(empty_msg),
    .nack_seen(nack_seen));

  twb_master i_mst (.scl(scl), .sda(sda), .scl_drive(m_scl),
    .sda_drive(m_sda));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Odd offset keeps link edges off every master edge except those timed from a stretch release
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #6 link_clk = ~link_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    n_rx += int'(rx_valid === 1'b1);
    n_empty += int'(empty_msg === 1'b1);
    n_req += int'(tx_req === 1'b1);
    n_nack += int'(nack_seen === 1'b1);
    n_stop += int'(stop_seen === 1'b1);
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  // Slave data must not move while the clock is high
  always @(posedge scl)
  begin
    #2;
    hold = sda_oe;
  end
  always @(negedge scl)
  begin
    if (rst === 1'b0)
      check(8'(sda_oe), 8'(hold));
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    link_rst = 1'b1;
    pwr_down = 1'b0;
    own = 7'h2a;
    gce = 1'b0;
    acken = 1'b1;
    tx_data = 8'h00;
    tx_load = 1'b0;
    idle(12);
    rst = 1'b0;
    link_rst = 1'b0;
    idle(4);
    check({2'b0, bus_busy, addressed, read_mode, gen_call, scl_oe, sda_oe},
      8'h00);
    check({6'h0, scl_o, sda_o}, 8'h00);
    foreach (rows[i])
    begin
      own = rows[i][30:24];
      gce = rows[i][14];
      acken = rows[i][13];
      idle(8);
      i_mst.start();
      i_mst.byte_xfer(rows[i][23:16], 1'b1, q, a);
      check(8'(a), 8'(!rows[i][12]));
      idle(6);
      check({6'h0, bus_busy, addressed}, {7'h01, rows[i][12]});
      check(8'(gen_call), 8'(rows[i][12] & ~|rows[i][23:16]));
      if (rows[i][12])
      begin
        i_mst.byte_xfer(rows[i][7:0], 1'b1, q, a);
        check(8'(a), 8'h00);
        e_rx++;
        idle(6);
        check(rx_data, rows[i][7:0]);
      end
      else
        e_empty++;
      i_mst.stop();
      idle(8);
      check(8'(bus_busy), 8'h00);
      check(8'(n_rx), 8'(e_rx));
      check(8'(n_empty), 8'(e_empty));
    end
    // Repeated start keeps the bus and restarts addressing
    own = 7'h2a;
    acken = 1'b1;
    gce = 1'b0;
    idle(4);
    i_mst.start();
    i_mst.byte_xfer(8'h54, 1'b1, q, a);
    i_mst.byte_xfer(8'h5a, 1'b1, q, a);
    i_mst.start();
    idle(6);
    check(8'(bus_busy), 8'h01);
    i_mst.byte_xfer(8'h54, 1'b1, q, a);
    check(8'(a), 8'h00);
    i_mst.byte_xfer(8'hc3, 1'b1, q, a);
    i_mst.stop();
    idle(8);
    check(rx_data, 8'hc3);
    check(8'(n_rx), 8'(e_rx + 2));
    // Start straight into stop
    i_mst.start();
    i_mst.stop();
    idle(8);
    check(8'(n_empty), 8'(e_empty + 1));
    // Read with no preload: slave stretches until each byte arrives
    fork
      begin
        i_mst.start();
        i_mst.byte_xfer(8'h55, 1'b1, q, a);
        check(8'(a), 8'h00);
        idle(4);
        check(8'(read_mode), 8'h01);
        i_mst.byte_xfer(8'hff, 1'b0, q, a);
        i_mst.byte_xfer(8'hff, 1'b1, q2, a);
        i_mst.stop();
      end
      repeat (2)
      begin
        @(posedge clk iff tx_req === 1'b1);
        @(negedge clk);
        check(8'(scl_oe), 8'h01);
        tx_data = (tx_data == 8'h81) ? 8'h3c : 8'h81;
        tx_load = 1'b1;
        @(negedge clk);
        tx_load = 1'b0;
      end
    join
    idle(8);
    check(q, 8'h81);
    check(q2, 8'h3c);
    check(8'(n_req), 8'h02);
    check(8'(n_nack), 8'h01);
    // Preloaded byte goes out with no stretch
    tx_data = 8'ha5;
    tx_load = 1'b1;
    @(negedge clk);
    tx_load = 1'b0;
    idle(4);
    i_mst.start();
    i_mst.byte_xfer(8'h55, 1'b1, q, a);
    i_mst.byte_xfer(8'hff, 1'b1, q, a);
    i_mst.stop();
    idle(8);
    check(q, 8'ha5);
    check(8'(n_req), 8'h02);
    check(8'(n_nack), 8'h02);
    // Powered down: no answer, no busy tracking
    pwr_down = 1'b1;
    idle(8);
    i_mst.start();
    i_mst.byte_xfer(8'h54, 1'b1, q, a);
    idle(6);
    check({6'h0, a, bus_busy}, 8'h02);
    i_mst.stop();
    idle(8);
    pwr_down = 1'b0;
    check(8'(n_stop), 8'h0c);
    complete_run();
  end

endmodule // testbench
